// >>> verilog/tmw_consts.svh
// Constants of the mode/control timer: offsets, fields, resets, counts.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
//
// How it works
// - Run bit 7 of timer_mode stops all counting at 0, lets it at 1.
// - Bits 6 and 3 of timer_mode always read back as 1.
// - Mode bit 5 turns general_reg_d into the buffer of general_reg_b.
// - Mode bit 4 turns general_reg_c into the buffer of general_reg_a.
// - Mode bits 2, 1, 0 put channels D, C, B into pulse output mode.
// - Control bit 7 clears the count on match A, else it runs free.
// - Clock select 000/001/010/011 count clk, /2, /4, /8; 1XX events.
// - With clk selected, the subclock is counted in low-power modes.
// - Control bits 3..0 are the D..A pin levels, applied at once.
// - Channel A pin is compare output or capture input, never pulse.
// - Pins B..D are compare out, capture in, or pulse out if enabled.
// - The counter and the four general registers are 16 bits wide.
// - The wrap flag is set when the count rolls from ffff to 0000.

`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TMW_ADR_MODE   8'h00
`define TMW_ADR_CTRL   8'h04
`define TMW_ADR_COUNT  8'h08
`define TMW_ADR_GRA    8'h0c
`define TMW_ADR_STAT   8'h1c
`define TMW_ADR_IOSEL  8'h20

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define TMW_MODE_RUN   7
`define TMW_MODE_BUFD  5
`define TMW_MODE_BUFC  4
`define TMW_MODE_PULSE_MODE_CHAN_D  2
`define TMW_MODE_PULSE_MODE_CHAN_C  1
`define TMW_MODE_PULSE_MODE_CHAN_B  0
`define TMW_MODE_RSVD  8'h48
`define TMW_MODE_WMASK 8'hb7
`define TMW_CTRL_CLR   7
`define TMW_CKS_HI     6
`define TMW_CKS_LO     4
`define TMW_STAT_WRAP  7
`define TMW_MODE_RST   8'h00
`define TMW_CTRL_RST   8'h00
`define TMW_IOSEL_RST  4'h0
`define TMW_CNT_MAX    16'hffff
`define TMW_GR_RST     16'hffff

`endif

// >>> verilog/tmw_pkg.sv
// Types shared by the timer files.
// Assumes tmw_consts.svh is on the include path.

package tmw_pkg;

    typedef logic [15:0] tmw_word_t;
    typedef logic [7:0]  tmw_addr_t;

    typedef enum logic [2:0] {
        TMW_SRC_FULL,
        TMW_SRC_DIV2,
        TMW_SRC_DIV4,
        TMW_SRC_DIV8,
        TMW_SRC_EXT
    } tmw_src_t;

    typedef struct packed {
        logic [7:0]      mode;
        logic [7:0]      ctrl;
        tmw_word_t       count;
        tmw_word_t [3:0] gr;
        logic            wrap;
        logic [3:0]      capsel;
        logic [3:0]      pin_prev;
        logic            ext_prev;
        logic            ack;
        logic [31:0]     dat;
    } tmw_state_t;

endpackage

// >>> verilog/tmw_prescale.sv
// Free-running divider giving one-cycle enables at clk/2, /4 and /8.
// Assumes one clock and a synchronous active-high reset.

`timescale 1ns/1ps

module tmw_prescale #(
    parameter int DIV_W = 3
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      div2_o,
    output logic      div4_o,
    output logic      div8_o
);

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;

    // Three stages are the least that can make the /8 enable
    if (DIV_W < 3) begin : g_width_check
        $error("tmw_prescale: DIV_W must be at least 3");
    end

    always_comb begin
        cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Enables fire once per period, all aligned on the same wrap
    assign div2_o = (cnt_reg[0] == 1'b1);
    assign div4_o = (cnt_reg[1:0] == 2'h3);
    assign div8_o = (cnt_reg[2:0] == 3'h7);

endmodule

// >>> verilog/tmw_timer.sv
// Timer mode/control block with counter, four channels, Wishbone slave.
// Assumes pins and event inputs are synchronous to clk_i and that the
// subclock tick is a one-cycle enable made elsewhere.

`timescale 1ns/1ps

`include "tmw_consts.svh"

module tmw_timer (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire tmw_pkg::tmw_addr_t adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic [31:0]            dat_o,
    output logic                   ack_o,
    input  wire logic              sub_mode_i,
    input  wire logic              subclk_tick_i,
    input  wire logic              ext_event_pin_i,
    input  wire logic              chan_a_pin_i,
    output logic                   chan_a_pin_o,
    output logic                   chan_a_pin_oe_o,
    input  wire logic              chan_b_pin_i,
    output logic                   chan_b_pin_o,
    output logic                   chan_b_pin_oe_o,
    input  wire logic              chan_c_pin_i,
    output logic                   chan_c_pin_o,
    output logic                   chan_c_pin_oe_o,
    input  wire logic              chan_d_pin_i,
    output logic                   chan_d_pin_o,
    output logic                   chan_d_pin_oe_o,
    output logic                   wrap_flag_o
);

    import tmw_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic tmw_word_t wr16(input tmw_word_t old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
        tmw_word_t r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic tmw_src_t src_of(input logic [2:0] cks);
        tmw_src_t r;
        r = TMW_SRC_FULL;
        case (cks)
            3'h0: begin
                r = TMW_SRC_FULL;
            end
            3'h1: begin
                r = TMW_SRC_DIV2;
            end
            3'h2: begin
                r = TMW_SRC_DIV4;
            end
            3'h3: begin
                r = TMW_SRC_DIV8;
            end
            default: begin
                r = TMW_SRC_EXT;
            end
        endcase
        return r;
    endfunction

    function automatic logic gr_hit(input tmw_addr_t a, input int i);
        return a == (`TMW_ADR_GRA + 8'(i * 4));
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    tmw_state_t st_reg;
    tmw_state_t st_next;

    logic       div2;
    logic       div4;
    logic       div8;
    logic [3:0] pin_in;
    logic       tick;
    logic       src_tick;
    logic       ext_rise;
    logic [3:0] match;
    logic [3:0] cap;
    logic [3:0] pwm;
    logic       buf_c;
    logic       buf_d;
    logic       req;
    logic       wr;
    logic       wrap_set;
    logic       wrap_clr;
    logic       clr_a;
    logic [31:0] rdata;

    tmw_prescale #(
        .DIV_W (3)
    ) u_prescale (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .div2_o (div2),
        .div4_o (div4),
        .div8_o (div8)
    );

    assign pin_in = {chan_d_pin_i, chan_c_pin_i, chan_b_pin_i, chan_a_pin_i};
    assign buf_c  = st_reg.mode[`TMW_MODE_BUFC];
    assign buf_d  = st_reg.mode[`TMW_MODE_BUFD];
    // Channel A has no pulse mode
    assign pwm    = {st_reg.mode[`TMW_MODE_PULSE_MODE_CHAN_D],
                     st_reg.mode[`TMW_MODE_PULSE_MODE_CHAN_C],
                     st_reg.mode[`TMW_MODE_PULSE_MODE_CHAN_B], 1'b0};
    assign req    = cyc_i && stb_i && !st_reg.ack;
    assign wr     = req && we_i;

    // ----------------------------------------------------------------
    // Count source
    // ----------------------------------------------------------------
    // Event pin edge detect
    assign ext_rise = ext_event_pin_i && !st_reg.ext_prev;

    always_comb begin
        src_tick = 1'b0;
        case (src_of(st_reg.ctrl[`TMW_CKS_HI:`TMW_CKS_LO]))
            TMW_SRC_FULL: begin
                src_tick = sub_mode_i ? subclk_tick_i : 1'b1;
            end
            TMW_SRC_DIV2: begin
                src_tick = div2;
            end
            TMW_SRC_DIV4: begin
                src_tick = div4;
            end
            TMW_SRC_DIV8: begin
                src_tick = div8;
            end
            TMW_SRC_EXT: begin
                src_tick = ext_rise;
            end
            default: begin
                src_tick = 1'b0;
            end
        endcase
    end

    assign tick = st_reg.mode[`TMW_MODE_RUN] && src_tick;

    // ----------------------------------------------------------------
    // Match and capture events
    // ----------------------------------------------------------------
    // Buffer registers of C and D do no capture, and compare only to end a pulse
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            match[i] = tick && !st_reg.capsel[i]
                       && (st_reg.count == st_reg.gr[i]);
            cap[i]   = st_reg.capsel[i] && pin_in[i] && !st_reg.pin_prev[i];
        end
        if (buf_c) begin
            match[2] = 1'b0;
            cap[2]   = 1'b0;
        end
        if (buf_d) begin
            match[3] = 1'b0;
            cap[3]   = 1'b0;
        end
    end

    assign clr_a    = st_reg.ctrl[`TMW_CTRL_CLR] && match[0];
    assign wrap_set = tick && !clr_a && (st_reg.count == `TMW_CNT_MAX);
    assign wrap_clr = wr && sel_i[0] && (adr_i == `TMW_ADR_STAT)
                      && !dat_i[`TMW_STAT_WRAP];

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_i)
            `TMW_ADR_MODE: begin
                rdata[7:0] = st_reg.mode | `TMW_MODE_RSVD;
            end
            `TMW_ADR_CTRL: begin
                rdata[7:0] = st_reg.ctrl;
            end
            `TMW_ADR_COUNT: begin
                rdata[15:0] = st_reg.count;
            end
            `TMW_ADR_STAT: begin
                rdata[`TMW_STAT_WRAP] = st_reg.wrap;
            end
            `TMW_ADR_IOSEL: begin
                rdata[3:0] = st_reg.capsel;
            end
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (gr_hit(adr_i, i)) begin
                        rdata[15:0] = st_reg.gr[i];
                    end
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.ack      = req;
        st_next.pin_prev = pin_in;
        st_next.ext_prev = ext_event_pin_i;
        if (req && !we_i) begin
            st_next.dat = rdata;
        end

        if (tick) begin
            st_next.count = clr_a ? 16'h0000 : st_reg.count + 16'h0001;
        end

        // Set wins over a clear in the same cycle
        st_next.wrap = wrap_set || (st_reg.wrap && !wrap_clr);

        // C reloads A on match A
        if (buf_c && match[0]) begin
            st_next.gr[0] = st_reg.gr[2];
        end
        // D reloads B on match B
        if (buf_d && match[1]) begin
            st_next.gr[1] = st_reg.gr[3];
        end

        for (int i = 0; i < 4; i++) begin
            if (cap[i]) begin
                st_next.gr[i] = st_reg.count;
            end
        end
        // Old A value moves to C on capture
        if (buf_c && cap[0]) begin
            st_next.gr[2] = st_reg.gr[0];
        end
        // Old B value moves to D on capture
        if (buf_d && cap[1]) begin
            st_next.gr[3] = st_reg.gr[1];
        end

        // Pin levels: toggle on own match, or pulse set/reset
        for (int i = 0; i < 4; i++) begin
            if (pwm[i] && !st_reg.capsel[i]) begin
                // Pulse: high at period, low at own match
                if (match[0]) begin
                    st_next.ctrl[i] = 1'b1;
                end
                if (tick && st_reg.count == st_reg.gr[i]) begin
                    st_next.ctrl[i] = 1'b0;
                end
            end else if (match[i]) begin
                st_next.ctrl[i] = !st_reg.ctrl[i];
            end
        end

        // Software writes win over hardware updates, except a wrap set over a status clear
        if (wr) begin
            case (adr_i)
                `TMW_ADR_MODE: begin
                    if (sel_i[0]) begin
                        st_next.mode = dat_i[7:0] & `TMW_MODE_WMASK;
                    end
                end
                `TMW_ADR_CTRL: begin
                    // Levels reach the pins at this edge
                    if (sel_i[0]) begin
                        st_next.ctrl = dat_i[7:0];
                    end
                end
                `TMW_ADR_COUNT: begin
                    st_next.count = wr16(st_reg.count, dat_i, sel_i);
                end
                `TMW_ADR_IOSEL: begin
                    if (sel_i[0]) begin
                        st_next.capsel = dat_i[3:0];
                    end
                end
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (gr_hit(adr_i, i)) begin
                            st_next.gr[i] = wr16(st_reg.gr[i], dat_i, sel_i);
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.mode     <= `TMW_MODE_RST;
            st_reg.ctrl     <= `TMW_CTRL_RST;
            st_reg.count    <= 16'h0000;
            st_reg.gr       <= {4{`TMW_GR_RST}};
            st_reg.wrap     <= 1'b0;
            st_reg.capsel   <= `TMW_IOSEL_RST;
            st_reg.pin_prev <= 4'h0;
            st_reg.ext_prev <= 1'b0;
            st_reg.ack      <= 1'b0;
            st_reg.dat      <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign dat_o           = st_reg.dat;
    assign ack_o           = st_reg.ack;
    assign wrap_flag_o     = st_reg.wrap;
    assign chan_a_pin_o    = st_reg.ctrl[0];
    assign chan_b_pin_o    = st_reg.ctrl[1];
    assign chan_c_pin_o    = st_reg.ctrl[2];
    assign chan_d_pin_o    = st_reg.ctrl[3];
    // Capture channels release the pin to the outside
    assign chan_a_pin_oe_o = !st_reg.capsel[0];
    assign chan_b_pin_oe_o = !st_reg.capsel[1];
    assign chan_c_pin_oe_o = !st_reg.capsel[2];
    assign chan_d_pin_oe_o = !st_reg.capsel[3];

endmodule

// >>> testbench/tmw_timer_checker.sv
// Checker of the timer's bus answers and pin outputs.
// Assumes a bind onto tmw_timer, one clock, synchronous reset.
`timescale 1ns/1ps
`include "tmw_consts.svh"
module tmw_timer_checker (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire tmw_pkg::tmw_addr_t adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    input  wire logic [31:0]        dat_o,
    input  wire logic               ack_o,
    input  wire logic               chan_a_pin_o,
    input  wire logic               chan_d_pin_o,
    input  wire logic               wrap_flag_o
);
    import tmw_pkg::*;
    logic take;
    logic wctl;
    logic wst;
    assign take = cyc_i && stb_i && !ack_o;
    assign wctl = take && we_i && adr_i == `TMW_ADR_CTRL && sel_i[0];
    assign wst = take && we_i && adr_i == `TMW_ADR_STAT;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    a_ack_pulse: assert property (
        ack_o |=> !ack_o) else $error("ack held too long");
    a_ack_answer: assert property (
        take |=> ack_o) else $error("no ack after request");
    a_ack_cause: assert property (
        !(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    // Read data may only move with an answer
    a_dat_hold: assert property (
        $changed(dat_o) |-> ack_o) else $error("read data moved");
    a_unmapped_zero: assert property (
        take && !we_i && adr_i == 8'h3c |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    // ----------------------------------------
    // Register fields and pins
    // ----------------------------------------
    a_rsvd_ones: assert property (
        take && !we_i && adr_i == `TMW_ADR_MODE |=> dat_o[6] && dat_o[3])
        else $error("reserved mode bits not one");
    a_level_a: assert property (
        wctl |=> chan_a_pin_o == $past(dat_i[0]))
        else $error("pin a level not applied");
    a_level_d: assert property (
        wctl |=> chan_d_pin_o == $past(dat_i[3]))
        else $error("pin d level not applied");
    a_wrap_keep: assert property (
        wrap_flag_o && !wst |=> wrap_flag_o) else $error("wrap flag lost");
endmodule

// >>> testbench/tmw_pins_model.sv
// Model of the event source and the loads on the channel pins.
// Assumes requests arrive as one-cycle pulses just after an edge.
`timescale 1ns/1ps
module tmw_pins_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ev_req_i,
    input  wire logic [3:0] cap_lvl_i,
    input  wire logic [3:0] pin_out_i,
    input  wire logic [3:0] pin_oe_i,
    output logic            ext_event_o,
    output logic [3:0]      pin_lvl_o
);
    logic [1:0] hold_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg <= 2'h0;
        end else if (ev_req_i) begin
            hold_reg <= 2'h2;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end
    // Two cycles high so the edge is seen
    assign ext_event_o = hold_reg != 2'h0;
    assign pin_lvl_o = (pin_out_i & pin_oe_i) | (cap_lvl_i & ~pin_oe_i);
endmodule

// >>> testbench/tmw_timer_tb.sv
// Self-checking bench of the timer mode/control block.
// Assumes the checker and the pin model are compiled before it.
`timescale 1ns/1ps
`include "tmw_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tmw_timer_tb;
    import tmw_pkg::*;
    logic        clk, rst, req, we, ack, sub, subt, ext, evq, wrap;
    tmw_addr_t   adr;
    logic [3:0]  po, oe, pi, cap;
    logic [31:0] dat, rd, q0, q1;
    logic [7:0]  h [4];
    int          n_errors, check_count;
    tmw_timer u_tmw_timer (
        .clk_i(clk), .rst_i(rst), .cyc_i(req), .stb_i(req), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rd), .ack_o(ack),
        .sub_mode_i(sub), .subclk_tick_i(subt), .ext_event_pin_i(ext),
        .chan_a_pin_i(pi[0]), .chan_a_pin_o(po[0]), .chan_a_pin_oe_o(oe[0]),
        .chan_b_pin_i(pi[1]), .chan_b_pin_o(po[1]), .chan_b_pin_oe_o(oe[1]),
        .chan_c_pin_i(pi[2]), .chan_c_pin_o(po[2]), .chan_c_pin_oe_o(oe[2]),
        .chan_d_pin_i(pi[3]), .chan_d_pin_o(po[3]), .chan_d_pin_oe_o(oe[3]),
        .wrap_flag_o(wrap));
    tmw_pins_model u_tmw_pins_model (
        .clk_i(clk), .rst_i(rst), .ev_req_i(evq), .cap_lvl_i(cap),
        .pin_out_i(po), .pin_oe_i(oe), .ext_event_o(ext), .pin_lvl_o(pi));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Classic cycle, held until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input tmw_addr_t a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            wrap_up();
        end
        q = rd;
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input tmw_addr_t a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdv(input tmw_addr_t a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic t_reset;
        rdv(`TMW_ADR_MODE, q0);
        `CHK(q0, 32'h48)
        rdv(`TMW_ADR_CTRL, q0);
        `CHK(q0, 32'h0)
        rdv(`TMW_ADR_GRA, q0);
        `CHK(q0, 32'hffff)
        rdv(8'h3c, q0);
        `CHK(q0, 32'h0)
        `CHK({oe, po, wrap}, 9'h1e0)
    endtask
    task automatic t_mode;
        wr(`TMW_ADR_MODE, 32'h37);
        rdv(`TMW_ADR_MODE, q0);
        `CHK(q0, 32'h7f)
        wr(`TMW_ADR_MODE, 32'h0);
    endtask
    task automatic t_levels;
        for (int i = 0; i < 4; i++) begin
            wr(`TMW_ADR_CTRL, 32'h1 << i);
            `CHK(po, 4'h1 << i)
        end
    endtask
    task automatic t_rates;
        for (int k = 0; k < 4; k++) begin
            wr(`TMW_ADR_CTRL, 32'(k) << 4);
            wr(`TMW_ADR_MODE, 32'h80);
            rdv(`TMW_ADR_COUNT, q0);
            repeat (61) @(posedge clk);
            rdv(`TMW_ADR_COUNT, q1);
            `CHK(q1[15:0] - q0[15:0], 16'd64 >> k)
        end
        wr(`TMW_ADR_MODE, 32'h0);
        rdv(`TMW_ADR_COUNT, q0);
        repeat (61) @(posedge clk);
        rdv(`TMW_ADR_COUNT, q1);
        `CHK(q1, q0)
    endtask
    task automatic t_events;
        for (int k = 4; k < 8; k += 3) begin
            wr(`TMW_ADR_CTRL, 32'(k) << 4);
            wr(`TMW_ADR_MODE, 32'h80);
            rdv(`TMW_ADR_COUNT, q0);
            repeat (5) begin
                evq <= 1'b1;
                @(posedge clk);
                evq <= 1'b0;
                repeat (5) @(posedge clk);
            end
            rdv(`TMW_ADR_COUNT, q1);
            `CHK(q1[15:0] - q0[15:0], 16'd5)
        end
        wr(`TMW_ADR_CTRL, 32'h0);
        sub <= 1'b1;
        rdv(`TMW_ADR_COUNT, q0);
        repeat (6) begin
            subt <= 1'b1;
            @(posedge clk);
            subt <= 1'b0;
            repeat (3) @(posedge clk);
        end
        rdv(`TMW_ADR_COUNT, q1);
        sub <= 1'b0;
        `CHK(q1[15:0] - q0[15:0], 16'd6)
    endtask
    task automatic t_pulse;
        wr(`TMW_ADR_MODE, 32'h0);
        wr(`TMW_ADR_COUNT, 32'h0);
        for (int j = 0; j < 4; j++) begin
            wr(`TMW_ADR_GRA + 8'(4 * j), 32'(j == 0 ? 9 : j + 2 + j / 2));
            h[j] = 8'h0;
        end
        wr(`TMW_ADR_CTRL, 32'h80);
        wr(`TMW_ADR_MODE, 32'h87);
        repeat (40) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            for (int j = 0; j < 4; j++) h[j] = h[j] + 8'(po[j]);
        end
        `CHK(h[0], 8'd20)
        `CHK({h[1], h[2], h[3]}, {8'd16, 8'd24, 8'd28})
        rdv(`TMW_ADR_COUNT, q0);
        `CHK(q0[15:0] < 16'd10, 1'b1)
        // Stopped count makes the captured value known
        wr(`TMW_ADR_MODE, 32'h0);
        wr(`TMW_ADR_COUNT, 32'h1234);
        wr(`TMW_ADR_IOSEL, 32'h2);
        `CHK(oe, 4'hd)
        cap <= 4'h2;
        repeat (3) @(posedge clk);
        cap <= 4'h0;
        rdv(`TMW_ADR_GRA + 8'h04, q0);
        `CHK(q0, 32'h1234)
        wr(`TMW_ADR_IOSEL, 32'h0);
    endtask
    task automatic t_buffer;
        wr(`TMW_ADR_MODE, 32'h0);
        wr(`TMW_ADR_COUNT, 32'h0);
        wr(`TMW_ADR_GRA, 32'h9);
        wr(`TMW_ADR_GRA + 8'h04, 32'h7);
        wr(`TMW_ADR_GRA + 8'h08, 32'h8);
        wr(`TMW_ADR_GRA + 8'h0c, 32'h2);
        wr(`TMW_ADR_MODE, 32'hb0);
        repeat (30) @(posedge clk);
        wr(`TMW_ADR_MODE, 32'h0);
        rdv(`TMW_ADR_GRA, q0);
        `CHK(q0, 32'h8)
        rdv(`TMW_ADR_GRA + 8'h04, q0);
        `CHK(q0, 32'h2)
    endtask
    task automatic t_wrap;
        wr(`TMW_ADR_CTRL, 32'h0);
        wr(`TMW_ADR_COUNT, 32'hfff0);
        `CHK(wrap, 1'b0)
        wr(`TMW_ADR_MODE, 32'h80);
        repeat (30) @(posedge clk);
        wr(`TMW_ADR_MODE, 32'h0);
        `CHK(wrap, 1'b1)
        wr(`TMW_ADR_STAT, 32'h0);
        `CHK(wrap, 1'b0)
    endtask
    initial begin
        {rst, req, we, sub, subt, evq, adr, dat, cap} = {1'b1, 49'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_mode();
        t_levels();
        t_rates();
        t_events();
        t_pulse();
        t_buffer();
        t_wrap();
        wrap_up();
    end
endmodule
bind tmw_timer tmw_timer_checker u_tmw_timer_checker (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .chan_a_pin_o, .chan_d_pin_o, .wrap_flag_o);
